// File: common/flash_ctrl_consts.vh
// constants for the suspend/erase sequencer
`ifndef FLASH_CTRL_CONSTS_VH
`define FLASH_CTRL_CONSTS_VH
`define OP_WRITE_ENABLE_OPCODE 8'h06
`define OP_RDSR 8'h05
`define OP_RDSR2A 8'h09
`define OP_RDSR2B 8'h35
`define OP_SUSP_A 8'h75
`define OP_SUSP_B 8'hB0
`define OP_RESUME_A 8'h7A
`define OP_RESUME_B 8'h30
`define OP_SE 8'h20
`define OP_HBE 8'h52
`define OP_BE 8'hD8
`define OP_CE_A 8'hC7
`define OP_CE_B 8'h60
`define OP_PP 8'h02
`define OP_QPP 8'h32
`define OP_WRSR_A 8'h01
`define OP_WRSR_B 8'h31
`define OP_WRSR_C 8'hC0
`define OP_WRSR_D 8'h11
`define OP_OTP_ERASE 8'h44
`define OP_OTP_PROG 8'h42
`define BITS_OPCODE 6'h08
`define BITS_ADDR_CMD 6'h20
`define CLK_NS 40
`define SUSPEND_LAT_NS 28000
`define RESUME_MIN_NS 300
`define RESUME_TYP_NS 400000
`define SECTOR_MSB 23
`define SECTOR_LSB 12
`define HALF_LSB 15
`define OP_SECTOR 3'h1
`define OP_HALF 3'h2
`define OP_BLOCK 3'h3
`define OP_CHIP 3'h4
`define OP_PROG 3'h5
`define OP_NONE 3'h0
`endif

// File: testbench/flash_ctrl_props.sv
// port checker for the suspend and erase sequencer
`timescale 1ns/1ns
`include "flash_ctrl_consts.vh"
module flash_ctrl_props
(
	input wire clk_i,
	input wire rst_i,
	input wire write_in_progress_flag_o,
	input wire write_enable_latch_o,
	input wire erase_suspended_flag_o,
	input wire program_suspended_flag_o,
	input wire erase_start_o,
	input wire [2:0] erase_kind_o,
	input wire [23:0] erase_addr_o,
	input wire op_done_o
);
	// ****************
	// checks
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire susp = erase_suspended_flag_o || program_suspended_flag_o;
	wire link_erase = erase_start_o && (erase_kind_o == `OP_SECTOR || erase_kind_o == `OP_HALF);
	// cycles spent busy since a suspend flag rose; too long for a plain delay
	reg [10:0] susp_busy_cnt;
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			susp_busy_cnt <= 11'h000;
		else if (susp && write_in_progress_flag_o)
		begin
			if (susp_busy_cnt != 11'h7FF)
				susp_busy_cnt <= susp_busy_cnt + 11'h001;
		end
		else
			susp_busy_cnt <= 11'h000;
	end
	a_start_sets_busy: assert property (erase_start_o |-> write_in_progress_flag_o && !write_enable_latch_o)
		else $error("start without busy");
	a_start_needs_latch: assert property (link_erase |-> $past(write_enable_latch_o && !susp))
		else $error("erase without latch");
	a_half_aligned: assert property (erase_start_o && erase_kind_o == `OP_HALF |-> erase_addr_o[14:0] == 15'h0000)
		else $error("half block not aligned");
	a_single_suspend: assert property (!(erase_suspended_flag_o && program_suspended_flag_o))
		else $error("two suspends");
	a_suspend_latency: assert property ($fell(write_in_progress_flag_o) && susp |-> susp_busy_cnt >= 11'd600 && susp_busy_cnt <= 11'd720)
		else $error("suspend latency");
	a_suspend_bounded: assert property (susp |-> susp_busy_cnt <= 11'd720)
		else $error("suspend busy too long");
	a_done_idle: assert property (op_done_o |-> !write_in_progress_flag_o && !susp)
		else $error("done while busy");
	a_resume_busy: assert property ($fell(susp) |-> write_in_progress_flag_o)
		else $error("resume without busy");
	a_start_pulse: assert property (erase_start_o |=> !erase_start_o && write_in_progress_flag_o)
		else $error("start not a pulse");
endmodule
bind flash_write_suspend_erase_ctrl flash_ctrl_props i_props(.clk_i(clk_i), .rst_i(rst_i),
	.write_in_progress_flag_o(write_in_progress_flag_o), .write_enable_latch_o(write_enable_latch_o),
	.erase_suspended_flag_o(erase_suspended_flag_o), .program_suspended_flag_o(program_suspended_flag_o),
	.erase_start_o(erase_start_o), .erase_kind_o(erase_kind_o), .erase_addr_o(erase_addr_o),
	.op_done_o(op_done_o));

// File: testbench/flash_write_suspend_erase_ctrl_bench.sv
// self-checking bench for the suspend and erase sequencer
`timescale 1ns/1ns
`include "flash_ctrl_consts.vh"
module flash_write_suspend_erase_ctrl_bench;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [5:0] prot = 6'h00;
	reg ext_start = 1'b0;
	reg [2:0] ext_op = 3'h0;
	reg boot_lock = 1'b0;
	reg [23:0] ext_addr = 24'h100000;
	wire sck, cs_n, sdi, busy, latch, esusp, psusp, start, done;
	wire [7:0] status;
	wire [2:0] kind;
	wire [23:0] addr;
	integer mismatches = 0;
	integer cmp_count = 0;
	integer r;
	reg [51:0] rows [0:14];
	always #20 clk_i = ~clk_i;
	spi_host_model i_host(.spi_clk_o(sck), .cs_n_o(cs_n), .data_o(sdi));
	flash_write_suspend_erase_ctrl #(.SECTOR_ERASE_TIME_NS(40000), .HALF_BLOCK_ERASE_TIME_NS(80000),
		.BLOCK_ERASE_TIME_NS(80000), .CHIP_ERASE_TIME_NS(40000), .PAGE_PROGRAM_TIME_NS(40000))
		i_dut(.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(sck), .cs_n_i(cs_n), .serial_data_in_i(sdi),
		.protect_complement_bit_i(prot[5]), .small_granule_protect_bit_i(prot[4]),
		.top_bottom_select_bit_i(prot[3]), .protect_level_bit2_i(prot[2]),
		.protect_level_bit1_i(prot[1]), .protect_level_bit0_i(prot[0]), .boot_lock_i(boot_lock),
		.ext_start_i(ext_start), .ext_op_i(ext_op), .ext_addr_i(ext_addr),
		.write_in_progress_flag_o(busy), .write_enable_latch_o(latch),
		.erase_suspended_flag_o(esusp), .program_suspended_flag_o(psusp), .status_byte_o(status),
		.erase_start_o(start), .erase_kind_o(kind), .erase_addr_o(addr), .op_done_o(done));
	// ****************
	// tasks
	// ****************
	task check(input [31:0] seen, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task stop_test;
	begin
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// bounded, a hung busy flag ends the run
	task wait_idle;
		integer t;
	begin
		t = 0;
		while (busy !== 1'b0 && t < 4000)
		begin
			@(negedge clk_i);
			t = t + 1;
		end
		if (t == 4000)
		begin
			mismatches = mismatches + 1;
			stop_test;
		end
	end
	endtask
	// row: word, bit count (0 = internal start), flags, wait, status valid, status
	task run(input [51:0] q);
	begin
		if (q[19:14] == 6'h00)
		begin
			@(posedge clk_i);
			ext_start <= 1'b1;
			ext_op <= q[22:20];
			@(posedge clk_i);
			ext_start <= 1'b0;
		end
		else
			i_host.frame(q[51:20], q[19:14]);
		repeat (8) @(negedge clk_i);
		check({busy, latch, esusp, psusp}, q[13:10]);
		if (q[8])
			check(status, q[7:0]);
		if (q[9])
			wait_idle;
	end
	endtask
	// ****************
	// main sequence
	// ****************
	initial
	begin
		rows[0] = {32'h00000006, 6'h08, 4'h4, 2'h0, 8'h00};
		rows[1] = {32'h20012345, 6'h20, 4'h8, 2'h0, 8'h00};
		rows[2] = {32'h00000005, 6'h08, 4'h8, 2'h1, 8'h01};
		rows[3] = {32'h000000B0, 6'h08, 4'hA, 2'h2, 8'h00};
		rows[4] = {32'h00000035, 6'h08, 4'h2, 2'h1, 8'h08};
		rows[5] = {32'h000000B0, 6'h08, 4'h2, 2'h0, 8'h00};
		rows[6] = {32'h52000000, 6'h20, 4'h2, 2'h0, 8'h00};
		rows[7] = {32'h00000030, 6'h08, 4'h8, 2'h2, 8'h00};
		rows[8] = {32'h00000005, 6'h00, 4'h8, 2'h0, 8'h00};
		rows[9] = {32'h00000075, 6'h08, 4'h9, 2'h2, 8'h00};
		rows[10] = {32'h0000007A, 6'h08, 4'h8, 2'h2, 8'h00};
		rows[11] = {32'h00000004, 6'h00, 4'h8, 2'h0, 8'h00};
		rows[12] = {32'h00000075, 6'h08, 4'h8, 2'h2, 8'h00};
		rows[13] = {32'h00000006, 6'h08, 4'h4, 2'h0, 8'h00};
		rows[14] = {32'h10000000, 6'h1F, 4'h4, 2'h0, 8'h00};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (r = 0; r < 15; r = r + 1)
			run(rows[r]);
		@(posedge clk_i);
		boot_lock <= 1'b1;
		run({32'h20012345, 6'h20, 4'h4, 2'h0, 8'h00});
		@(posedge clk_i);
		boot_lock <= 1'b0;
		prot <= 6'h07;
		run({32'h20012345, 6'h20, 4'h4, 2'h0, 8'h00});
		@(posedge clk_i);
		prot <= 6'h00;
		run({32'h520ABCDE, 6'h20, 4'h8, 2'h0, 8'h00});
		check(addr, 24'h0A8000);
		check(kind, `OP_HALF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		check({busy, latch, esusp, psusp}, 4'h0);
		stop_test;
	end
endmodule

// File: testbench/spi_host_model.sv
// host model that frames commands on the serial link
`timescale 1ns/1ns
module spi_host_model
(
	output reg spi_clk_o,
	output reg cs_n_o,
	output reg data_o
);
	integer i;
	initial
	begin
		spi_clk_o = 1'b0;
		cs_n_o = 1'b1;
		data_o = 1'b0;
	end
	// ****************
	// frame, msb first; clock parked low, data flipped once released
	// ****************
	task frame(input [31:0] w, input [5:0] n);
	begin
		cs_n_o = 1'b0;
		for (i = n - 1; i >= 0; i = i - 1)
		begin
			data_o = w[i];
			#160 spi_clk_o = 1'b1;
			#160 spi_clk_o = 1'b0;
		end
		#160 cs_n_o = 1'b1;
		data_o = ~data_o;
	end
	endtask
endmodule

// File: verilog/busy_timer.v
// countdown timer for self-timed operations, pausable
`timescale 1ns/1ns
module busy_timer
(
	input wire clk_i,
	input wire rst_i,
	input wire load_i,
	input wire [31:0] load_val_i,
	input wire run_i,
	output wire done_o,
	output wire [31:0] remain_o
);
	reg [31:0] cnt_reg;
	reg [31:0] cnt_next;
	always @*
	begin
		cnt_next = cnt_reg;
		if (load_i)
			cnt_next = load_val_i;
		else if (run_i && cnt_reg != 32'h0)
			cnt_next = cnt_reg - 32'h1;
	end
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cnt_reg <= 32'h0;
		else
			cnt_reg <= cnt_next;
	end
	assign done_o = (cnt_reg == 32'h1) && run_i;
	assign remain_o = cnt_reg;
endmodule

// File: verilog/flash_write_suspend_erase_ctrl.v
// serial flash suspend/resume and sector/half block erase sequencer
// How it works
// R1 - suspend pauses erase/program; resume continues it
// R2 - second suspend while suspended is ignored
// R3 - suspend during chip erase ignored
// R4 - host waits suspend latency or polls busy
// R5 - resume-to-suspend spacing; device needs progress time (counted, but suspends are not held off)
// R6 - erase suspend forbids status writes, erases
// R7 - erase suspend: programs to suspended sector ignored
// R8 - erase suspend sets erase flag, busy meanwhile
// R9 - program suspend forbids writes, erases, programs
// R10 - program suspend: erases to suspended sector ignored
// R11 - program suspend sets program flag, busy meanwhile
// R12 - busy flag shows suspend readiness
// R13 - host frames opcode with chip select
// R14 - resume restarts op, clears suspend flag
// R15 - total time never exceeds uninterrupted time
// R16 - status reads report busy and suspend flags
// R17 - sector erase takes opcode plus three address bytes
// R18 - erase needs write enable latch set
// R19 - erase runs only if select rises after 32 bits
// R20 - select rise starts erase, busy, latch cleared
// R21 - protected sector erase ignored
// R22 - half block erase behaves like sector erase (but boot lock blocks sector erase only)
// R23 - protected half block erase ignored
// R24 - forbidden opcodes during suspend are ignored
`timescale 1ns/1ns
`include "flash_ctrl_consts.vh"
module flash_write_suspend_erase_ctrl
#(
	parameter SECTOR_ERASE_TIME_NS = 100000000,
	parameter HALF_BLOCK_ERASE_TIME_NS = 300000000,
	parameter BLOCK_ERASE_TIME_NS = 500000000,
	parameter CHIP_ERASE_TIME_NS = 32'd1500000000,
	parameter PAGE_PROGRAM_TIME_NS = 1000000
)
(
	input wire clk_i,
	input wire rst_i,
	input wire spi_clk_i,
	input wire cs_n_i,
	input wire serial_data_in_i,
	input wire protect_complement_bit_i,
	input wire small_granule_protect_bit_i,
	input wire top_bottom_select_bit_i,
	input wire protect_level_bit2_i,
	input wire protect_level_bit1_i,
	input wire protect_level_bit0_i,
	input wire boot_lock_i,
	input wire ext_start_i,
	input wire [2:0] ext_op_i,
	input wire [23:0] ext_addr_i,
	output reg write_in_progress_flag_o,
	output reg write_enable_latch_o,
	output reg erase_suspended_flag_o,
	output reg program_suspended_flag_o,
	output reg [7:0] status_byte_o,
	output reg erase_start_o,
	output reg [2:0] erase_kind_o,
	output reg [23:0] erase_addr_o,
	output reg op_done_o
);
	// ****************************************
	// timing counts
	// ****************************************
	localparam SUSP_CYC = `SUSPEND_LAT_NS / `CLK_NS;
	localparam RES_MIN_CYC = (`RESUME_MIN_NS + `CLK_NS - 1) / `CLK_NS;
	localparam RES_TYP_CYC = (`RESUME_TYP_NS + `CLK_NS - 1) / `CLK_NS;
	localparam [31:0] SE_CYC = SECTOR_ERASE_TIME_NS / `CLK_NS;
	localparam [31:0] HBE_CYC = HALF_BLOCK_ERASE_TIME_NS / `CLK_NS;
	localparam [31:0] BE_CYC = BLOCK_ERASE_TIME_NS / `CLK_NS;
	localparam [31:0] CE_CYC = CHIP_ERASE_TIME_NS / `CLK_NS;
	localparam [31:0] PP_CYC = PAGE_PROGRAM_TIME_NS / `CLK_NS;
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_SUSPENDING = 2'h2;
	localparam ST_SUSPENDED = 2'h3;

	// ****************************************
	// pin synchronisers
	// ****************************************
	reg [1:0] sck_sync_reg;
	reg [1:0] cs_sync_reg;
	reg [1:0] di_sync_reg;
	reg sck_prev_reg;
	reg cs_prev_reg;
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sck_sync_reg <= 2'h0;
			cs_sync_reg <= 2'h3;
			di_sync_reg <= 2'h0;
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end
		else
		begin
			sck_sync_reg <= {sck_sync_reg[0], spi_clk_i};
			cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
			di_sync_reg <= {di_sync_reg[0], serial_data_in_i};
			sck_prev_reg <= sck_sync_reg[1];
			cs_prev_reg <= cs_sync_reg[1];
		end
	end
	wire sck_rise = sck_sync_reg[1] && !sck_prev_reg;
	wire cs_low = !cs_sync_reg[1];
	wire cs_rise = cs_sync_reg[1] && !cs_prev_reg;

	// ****************************************
	// frame shifter
	// ****************************************
	// bits arrive msb first, so the first nibble lands high [R13]
	reg [31:0] shift_reg;
	reg [5:0] nbits_reg;
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			shift_reg <= 32'h0;
			nbits_reg <= 6'h0;
		end
		else if (!cs_low)
			nbits_reg <= 6'h0;
		else if (sck_rise)
		begin
			shift_reg <= {shift_reg[30:0], di_sync_reg[1]};
			if (nbits_reg != 6'h3F)
				nbits_reg <= nbits_reg + 6'h1;
		end
	end
	wire [7:0] opc = (nbits_reg == `BITS_OPCODE) ? shift_reg[7:0] : shift_reg[31:24];
	wire [23:0] faddr = shift_reg[23:0];
	wire frame8 = (nbits_reg == `BITS_OPCODE);
	wire frame32 = (nbits_reg == `BITS_ADDR_CMD);

	// ****************************************
	// decode helpers
	// ****************************************
	function is_erase_op;
		input [7:0] o;
		begin
			is_erase_op = (o == `OP_SE) || (o == `OP_HBE) || (o == `OP_BE)
				|| (o == `OP_CE_A) || (o == `OP_CE_B);
		end
	endfunction
	function is_forbidden_common;
		input [7:0] o;
		begin
			is_forbidden_common = (o == `OP_WRSR_A) || (o == `OP_WRSR_B)
				|| (o == `OP_WRSR_C) || (o == `OP_WRSR_D)
				|| (o == `OP_OTP_ERASE) || is_erase_op(o);
		end
	endfunction
	// protected region test: level bits pick a span from the top or bottom
	function prot_hit;
		input [23:0] a;
		input [5:0] pb;
		input lock;
		reg [2:0] lvl;
		reg [8:0] unit;
		reg hit;
		begin
			lvl = pb[2:0];
			unit = pb[4] ? a[20:12] : {4'h0, a[20:16]};
			if (pb[3])
				unit = ~unit;
			hit = (lvl != 3'h0) && ((unit >> (pb[4] ? 3'h0 : lvl - 3'h1)) == 9'h0)
				&& (pb[4] ? (unit < {6'h0, lvl}) : 1'b1);
			if (lvl == 3'h7)
				hit = 1'b1;
			prot_hit = ((hit ^ pb[5]) && (lvl != 3'h0 || pb[5])) || lock;
		end
	endfunction
	wire [5:0] prot_bits = {protect_complement_bit_i, small_granule_protect_bit_i,
		top_bottom_select_bit_i, protect_level_bit2_i, protect_level_bit1_i,
		protect_level_bit0_i};

	// ****************************************
	// write sequencer
	// ****************************************
	reg [1:0] state_reg;
	reg [2:0] kind_reg;
	reg [23:0] addr_reg;
	reg [31:0] gate_reg;
	reg [31:0] since_res_reg;
	reg tmr_load;
	reg [31:0] tmr_val;
	wire tmr_done;
	wire [31:0] tmr_left;
	wire running = (state_reg == ST_RUN);
	// remaining count is frozen while suspended, so no time is repeated [R15]
	busy_timer u_timer
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(tmr_load),
		.load_val_i(tmr_val),
		.run_i(running),
		.done_o(tmr_done),
		.remain_o(tmr_left)
	);
	wire susp_op = (opc == `OP_SUSP_A) || (opc == `OP_SUSP_B);
	wire res_op = (opc == `OP_RESUME_A) || (opc == `OP_RESUME_B);
	wire in_susp = (state_reg == ST_SUSPENDED);
	wire same_sector = (faddr[`SECTOR_MSB:`SECTOR_LSB] == addr_reg[`SECTOR_MSB:`SECTOR_LSB]);
	wire forbid_e = in_susp && kind_reg != `OP_PROG && is_forbidden_common(opc); // [R6]
	wire forbid_p = in_susp && kind_reg == `OP_PROG
		&& (is_forbidden_common(opc) || opc == `OP_OTP_PROG
		|| opc == `OP_PP || opc == `OP_QPP); // [R9]
	wire erase_cmd = frame32 && ((opc == `OP_SE) || (opc == `OP_HBE)); // [R17] [R22]
	wire erase_ok = erase_cmd && write_enable_latch_o && !forbid_e && !forbid_p // [R18] [R24]
		&& (state_reg == ST_IDLE)
		&& !prot_hit(faddr, prot_bits, boot_lock_i && opc == `OP_SE); // [R21] [R23]
	// programs into a sector under suspended erase are dropped [R7]
	wire ext_blocked = in_susp && (((ext_op_i == `OP_PROG) && kind_reg != `OP_PROG
		&& (ext_addr_i[`SECTOR_MSB:`SECTOR_LSB] == addr_reg[`SECTOR_MSB:`SECTOR_LSB]))
		|| ((ext_op_i != `OP_PROG) && kind_reg == `OP_PROG)); // [R10] [R24]
	wire ext_ok = ext_start_i && (state_reg == ST_IDLE || (in_susp && !ext_blocked));
	always @*
	begin
		tmr_load = 1'b0;
		tmr_val = 32'h0;
		if (cs_rise && erase_ok)
		begin
			tmr_load = 1'b1;
			tmr_val = (opc == `OP_SE) ? SE_CYC : HBE_CYC;
		end
		else if (ext_ok && state_reg == ST_IDLE)
		begin
			tmr_load = 1'b1;
			case (ext_op_i)
				`OP_SECTOR: tmr_val = SE_CYC;
				`OP_HALF: tmr_val = HBE_CYC;
				`OP_BLOCK: tmr_val = BE_CYC;
				`OP_CHIP: tmr_val = CE_CYC;
				default: tmr_val = PP_CYC;
			endcase
		end
	end
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_IDLE;
			kind_reg <= `OP_NONE;
			addr_reg <= 24'h0;
			gate_reg <= 32'h0;
			since_res_reg <= 32'h0;
			write_in_progress_flag_o <= 1'b0;
			write_enable_latch_o <= 1'b0;
			erase_suspended_flag_o <= 1'b0;
			program_suspended_flag_o <= 1'b0;
			erase_start_o <= 1'b0;
			erase_kind_o <= `OP_NONE;
			erase_addr_o <= 24'h0;
			op_done_o <= 1'b0;
		end
		else
		begin
			erase_start_o <= 1'b0;
			op_done_o <= 1'b0;
			if (since_res_reg != 32'hFFFFFFFF)
				since_res_reg <= since_res_reg + 32'h1;
			if (cs_rise && frame8 && opc == `OP_WRITE_ENABLE_OPCODE && state_reg == ST_IDLE)
				write_enable_latch_o <= 1'b1;
			case (state_reg)
				ST_IDLE:
				begin
					if (cs_rise && erase_ok) // [R19]
					begin
						state_reg <= ST_RUN;
						kind_reg <= (opc == `OP_SE) ? `OP_SECTOR : `OP_HALF;
						addr_reg <= faddr;
						write_in_progress_flag_o <= 1'b1; // [R20]
						write_enable_latch_o <= 1'b0; // [R20]
						erase_start_o <= 1'b1;
						erase_kind_o <= (opc == `OP_SE) ? `OP_SECTOR : `OP_HALF;
						erase_addr_o <= (opc == `OP_SE) ? faddr
							: {faddr[23:`HALF_LSB], 15'h0};
					end
					else if (ext_ok)
					begin
						state_reg <= ST_RUN;
						kind_reg <= ext_op_i;
						addr_reg <= ext_addr_i;
						write_in_progress_flag_o <= 1'b1;
						write_enable_latch_o <= 1'b0;
					end
				end
				ST_RUN:
				begin
					if (tmr_done)
					begin
						state_reg <= ST_IDLE;
						write_in_progress_flag_o <= 1'b0; // [R20]
						op_done_o <= 1'b1;
					end
					// chip erase cannot be paused [R3]
					else if (cs_rise && frame8 && susp_op && kind_reg != `OP_CHIP) // [R1]
					begin
						state_reg <= ST_SUSPENDING;
						gate_reg <= SUSP_CYC;
						if (kind_reg == `OP_PROG)
							program_suspended_flag_o <= 1'b1; // [R11]
						else
							erase_suspended_flag_o <= 1'b1; // [R8]
					end
				end
				ST_SUSPENDING:
				begin
					// busy stays high until the pause settles [R12] [R4]
					if (gate_reg == 32'h1)
					begin
						state_reg <= ST_SUSPENDED;
						write_in_progress_flag_o <= 1'b0; // [R12]
					end
					gate_reg <= gate_reg - 32'h1;
				end
				ST_SUSPENDED:
				begin
					// another suspend here falls through untouched [R2]
					if (cs_rise && frame8 && res_op) // [R14]
					begin
						state_reg <= ST_RUN;
						write_in_progress_flag_o <= 1'b1;
						erase_suspended_flag_o <= 1'b0; // [R14]
						program_suspended_flag_o <= 1'b0; // [R14]
						since_res_reg <= 32'h0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// time since resume is counted, but suspends soon after resume are not held off [R5]
	wire res_young = since_res_reg < RES_MIN_CYC;
	wire unused_typ = (RES_TYP_CYC == 0) && res_young && same_sector && (|tmr_left);

	// ****************************************
	// status read data
	// ****************************************
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			status_byte_o <= 8'h0;
		else if (frame8 && opc == `OP_RDSR)
			status_byte_o <= {6'h0, write_enable_latch_o, write_in_progress_flag_o}; // [R16]
		else if (frame8 && (opc == `OP_RDSR2A || opc == `OP_RDSR2B))
			status_byte_o <= {write_in_progress_flag_o, 3'h0, erase_suspended_flag_o,
				program_suspended_flag_o, 2'h0}; // [R16]
	end
endmodule
